// ==== logic/adc_ctl_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH

// Register offsets on the plain register port
`define ADC_OFS_CTRL     4'h0
`define ADC_OFS_RESULT   4'h4
`define ADC_OFS_IRQ_STAT 4'h8
`define ADC_OFS_IRQ_MASK 4'hC
`define ADC_OFS_STATE    4'h1

// Control register field positions
`define ADC_CTRL_CLK_HI  7
`define ADC_CTRL_CLK_LO  6
`define ADC_CTRL_CH_HI   5
`define ADC_CTRL_CH_LO   3
`define ADC_CTRL_GO      2
`define ADC_CTRL_PWR     0

// Interrupt status and mask bit positions
`define ADC_IRQ_DONE     0

// State register bit positions
`define ADC_ST_BUSY      0
`define ADC_ST_HOLD      1
`define ADC_ST_ANA_ON    2
`define ADC_ST_ABORTWT   3

// Reset values
`define ADC_CTRL_RST     8'h00
`define ADC_MASK_RST     1'b0

// Conversion clock select codes
`define ADC_SEL_OSC2     2'h0
`define ADC_SEL_OSC8     2'h1
`define ADC_SEL_OSC32    2'h2
`define ADC_SEL_RC       2'h3

// Oscillator periods per conversion bit for each oscillator code
`define ADC_DIV_OSC2     6'h02
`define ADC_DIV_OSC8     6'h08
`define ADC_DIV_OSC32    6'h20

// One instruction cycle in oscillator periods, and the delay before an RC start
`define ADC_OSC_PER_INSTR 3'h4
`define ADC_RC_START_CLKS (`ADC_OSC_PER_INSTR)

// Conversion clock periods held after an abort before acquisition resumes
`define ADC_ABORT_WAIT_TAD 2'h2

// Result width in bits
`define ADC_RES_BITS     8

`endif

// ==== logic/adc_ctl_pkg.sv ====
// Types shared by the converter control and its approximation engine
package adc_ctl_pkg;

  // Software visible control bits
  typedef struct packed {
    logic [1:0] clk_sel;
    logic [2:0] chan;
    logic       go;
    logic       unused;
    logic       pwr_on;
  } adc_ctrl_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_RC_DELAY,
    SEQ_SAMPLE,
    SEQ_CONVERT,
    SEQ_ABORT_WAIT
  } seq_state_t;

endpackage

// ==== logic/sar_core.sv ====
// Successive approximation engine: one result bit per conversion clock tick
`timescale 1ns/1ps
`include "adc_ctl_cfg.svh"

module sar_core
  import adc_ctl_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Control from the sequencer
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       step,
  // Comparator: input at or above trial level
  input  wire logic       cmp_hi,
  // Results
  output logic [7:0]      trial_code,
  output logic            busy,
  output logic            done,
  output logic [7:0]      result
);

  logic [7:0] code_r;
  logic [7:0] bit_r;
  logic       busy_r;
  logic       done_r;
  logic [7:0] res_r;
  logic [7:0] kept;

  // Trial bit is dropped when the input sits below the trial level
  assign kept = cmp_hi ? code_r : (code_r & ~bit_r);

  // Bit walk, most significant first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      code_r <= 8'h00;
      bit_r  <= 8'h00;
      busy_r <= 1'b0;
    end else if (ce) begin
      if (abort) begin
        busy_r <= 1'b0;
        code_r <= 8'h00;
        bit_r  <= 8'h00;
      end else if (start) begin
        busy_r <= 1'b1;
        code_r <= 8'h80;
        bit_r  <= 8'h80;
      end else if (busy_r && step) begin
        if (bit_r == 8'h01) begin
          busy_r <= 1'b0;
          code_r <= kept;
        end else begin
          code_r <= kept | (bit_r >> 1);
        end
        bit_r <= bit_r >> 1;
      end
    end
  end

  // Finished code and its one-cycle completion pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
      res_r  <= 8'h00;
    end else if (ce) begin
      done_r <= busy_r && step && !abort && (bit_r == 8'h01);
      if (busy_r && step && !abort && (bit_r == 8'h01)) begin
        res_r <= kept;
      end
    end
  end

  assign trial_code = code_r;
  assign busy       = busy_r;
  assign done       = done_r;
  assign result     = res_r;

endmodule // sar_core

// ==== logic/adc_sleep_reset_control.sv ====
// Converter control: halt behaviour, reset effects, sampling and result capture
`timescale 1ns/1ps
`include "adc_ctl_cfg.svh"

module adc_sleep_reset_control
  import adc_ctl_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Processor halt state and wake request
  input  wire logic       halt_active,
  output logic            wake_req,
  // Internal RC oscillator output, asynchronous
  input  wire logic       rc_osc_in,
  // Analog front end
  input  wire logic       cmp_hi_in,
  output logic [7:0]      dac_code,
  output logic [2:0]      mux_chan,
  output logic            hold_connect,
  output logic            analog_power_en,
  // Interrupt and flag
  output logic            irq,
  output logic            conversion_done_flag
);

  reg_req_t   req;
  adc_ctrl_t  ctrl_r;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [7:0] conversion_result;
  logic [7:0] rdata_r;
  logic       stat_done_r;
  logic       conversion_irq_enable;
  logic       pwr_down_r;
  logic       halt_d_r;
  logic [5:0] tad_cnt_r;
  logic [2:0] dly_cnt_r;
  logic [1:0] wait_cnt_r;
  logic [2:0] chan_r;
  logic       rc_s1_r;
  logic       rc_s2_r;
  logic       rc_s3_r;
  logic       cmp_s1_r;
  logic       cmp_s2_r;
  logic       tad_tick;
  logic       osc_tick;
  logic       rc_tick;
  logic       rc_sel;
  logic       ctrl_wr;
  logic       go_wr_set;
  logic       go_wr_clr;
  logic       halt_enter;
  logic       halt_abort;
  logic       busy;
  logic       seq_busy;
  logic       sar_start;
  logic       sar_abort;
  logic       sar_busy;
  logic       sar_done;
  logic [7:0] sar_result;
  logic       done_evt;
  logic       in_halt;

  // Per-bit divide for the oscillator codes
  function automatic logic [5:0] tad_div(input logic [1:0] sel);
    unique case (sel)
      `ADC_SEL_OSC2:  tad_div = `ADC_DIV_OSC2;
      `ADC_SEL_OSC8:  tad_div = `ADC_DIV_OSC8;
      `ADC_SEL_OSC32: tad_div = `ADC_DIV_OSC32;
      `ADC_SEL_RC:    tad_div = `ADC_DIV_OSC2;
    endcase
  endfunction

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  assign rc_sel     = (ctrl_r.clk_sel == `ADC_SEL_RC);
  assign ctrl_wr    = req.wr && (req.addr == `ADC_OFS_CTRL);
  assign go_wr_set  = ctrl_wr && req.wdata[`ADC_CTRL_GO] && req.wdata[`ADC_CTRL_PWR];
  assign go_wr_clr  = ctrl_wr && !req.wdata[`ADC_CTRL_GO];
  assign halt_enter = halt_active && !halt_d_r;
  assign in_halt    = halt_active;
  assign seq_busy   = (state_r == SEQ_RC_DELAY) || (state_r == SEQ_SAMPLE)
                   || (state_r == SEQ_CONVERT);
  assign busy       = seq_busy || sar_busy;

  // Only an oscillator-clocked conversion dies at halt entry
  assign halt_abort = halt_enter && !rc_sel && seq_busy;

  // Asynchronous pins pass two flip-flops before use
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rc_s1_r  <= 1'b0;
      rc_s2_r  <= 1'b0;
      rc_s3_r  <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else if (ce) begin
      rc_s1_r  <= rc_osc_in;
      rc_s2_r  <= rc_s1_r;
      rc_s3_r  <= rc_s2_r;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  // Comparator first stage on the falling edge: a two-clock bit leaves half a cycle to resolve
  always_ff @(negedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_s1_r <= 1'b0;
    end else if (ce) begin
      cmp_s1_r <= cmp_hi_in;
    end
  end

  // RC bit clock is the rising edge of the synchronised oscillator
  assign rc_tick = rc_s2_r && !rc_s3_r;

  // Oscillator divider; restarts with each conversion so every bit is full length
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tad_cnt_r <= 6'h00;
    end else if (ce) begin
      if ((go_wr_set && state_r == SEQ_IDLE) || osc_tick) begin
        tad_cnt_r <= 6'h00;
      end else begin
        tad_cnt_r <= tad_cnt_r + 6'h01;
      end
    end
  end

  assign osc_tick = (tad_cnt_r == tad_div(ctrl_r.clk_sel) - 6'h01);
  assign tad_tick = rc_sel ? rc_tick : osc_tick;

  // Halt edge detector; halt comes from core logic on this clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      halt_d_r <= 1'b0;
    end else if (ce) begin
      halt_d_r <= halt_active;
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SEQ_IDLE: begin
        if (go_wr_set) begin
          state_nxt = (req.wdata[`ADC_CTRL_CLK_HI:`ADC_CTRL_CLK_LO] == `ADC_SEL_RC)
                    ? SEQ_RC_DELAY : SEQ_SAMPLE;
        end
      end
      SEQ_RC_DELAY: begin
        if (dly_cnt_r == `ADC_RC_START_CLKS - 3'h1) begin
          state_nxt = SEQ_SAMPLE;
        end
      end
      SEQ_SAMPLE: begin
        if (tad_tick) begin
          state_nxt = SEQ_CONVERT;
        end
      end
      SEQ_CONVERT: begin
        if (sar_done) begin
          state_nxt = SEQ_IDLE;
        end
      end
      SEQ_ABORT_WAIT: begin
        if (tad_tick && wait_cnt_r == `ADC_ABORT_WAIT_TAD - 2'h1) begin
          state_nxt = SEQ_IDLE;
        end
      end
    endcase
    if (seq_busy && (go_wr_clr || halt_abort)) begin
      state_nxt = SEQ_ABORT_WAIT;
    end
    if (ctrl_wr && !req.wdata[`ADC_CTRL_PWR]) begin
      state_nxt = SEQ_IDLE;
    end
  end

  // Sequencer state; reset aborts whatever was running
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= SEQ_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Instruction-cycle delay and post-abort wait counters
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dly_cnt_r  <= 3'h0;
      wait_cnt_r <= 2'h0;
    end else if (ce) begin
      dly_cnt_r <= (state_r == SEQ_RC_DELAY) ? dly_cnt_r + 3'h1 : 3'h0;
      if (state_r != SEQ_ABORT_WAIT) begin
        wait_cnt_r <= 2'h0;
      end else if (tad_tick) begin
        wait_cnt_r <= wait_cnt_r + 2'h1;
      end
    end
  end

  assign sar_start = (state_r == SEQ_SAMPLE) && tad_tick && (state_nxt == SEQ_CONVERT);
  assign sar_abort = (state_nxt == SEQ_ABORT_WAIT) || (state_nxt == SEQ_IDLE && !sar_done
                   && state_r == SEQ_CONVERT);
  assign done_evt  = sar_done && (state_r == SEQ_CONVERT);

  // Engine; comparator trips at input >= code steps, so code 1 begins at one step
  sar_core u_sar (
    .core_clk   (core_clk),
    .rst        (rst),
    .ce         (ce),
    .start      (sar_start),
    .abort      (sar_abort),
    .step       (tad_tick),
    .cmp_hi     (cmp_s2_r),
    .trial_code (dac_code),
    .busy       (sar_busy),
    .done       (sar_done),
    .result     (sar_result)
  );

  // Control register; hardware clears go on completion unless software restarts
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `ADC_CTRL_RST;
    end else if (ce) begin
      if (ctrl_wr) begin
        ctrl_r.clk_sel <= req.wdata[`ADC_CTRL_CLK_HI:`ADC_CTRL_CLK_LO];
        ctrl_r.chan    <= req.wdata[`ADC_CTRL_CH_HI:`ADC_CTRL_CH_LO];
        ctrl_r.pwr_on  <= req.wdata[`ADC_CTRL_PWR];
        ctrl_r.go      <= req.wdata[`ADC_CTRL_GO] && req.wdata[`ADC_CTRL_PWR];
      end else if (done_evt || halt_abort) begin
        ctrl_r.go <= 1'b0;
      end
      ctrl_r.unused <= 1'b0;
    end
  end

  // Result register has no reset term so reset leaves it as it was
  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (done_evt) begin
        conversion_result <= sar_result;
      end else if (req.wr && req.addr == `ADC_OFS_RESULT) begin
        conversion_result <= req.wdata;
      end
    end
  end

  // Done flag: completion wins over a same-cycle write-one clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_done_r <= 1'b0;
    end else if (ce) begin
      if (done_evt) begin
        stat_done_r <= 1'b1;
      end else if (req.wr && req.addr == `ADC_OFS_IRQ_STAT
                   && req.wdata[`ADC_IRQ_DONE]) begin
        stat_done_r <= 1'b0;
      end
    end
  end

  // Interrupt enable lives in the mask register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conversion_irq_enable <= `ADC_MASK_RST;
    end else if (ce) begin
      if (req.wr && req.addr == `ADC_OFS_IRQ_MASK) begin
        conversion_irq_enable <= req.wdata[`ADC_IRQ_DONE];
      end
    end
  end

  // Low-power shutdown leaves the power-on bit set; next halt exit or write restores
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_down_r <= 1'b1;
    end else if (ce) begin
      if (halt_abort || (halt_enter && !rc_sel)) begin
        pwr_down_r <= 1'b1;
      end else if (done_evt && in_halt && !conversion_irq_enable) begin
        pwr_down_r <= 1'b1;
      end else if (ctrl_wr || (!halt_active && halt_d_r)) begin
        pwr_down_r <= 1'b0;
      end
    end
  end

  // Wake pulse on a halted completion with the interrupt enabled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else if (ce) begin
      wake_req <= done_evt && in_halt && conversion_irq_enable;
    end
  end

  // Mux follows the channel only while the hold capacitor is connected
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chan_r <= 3'h0;
    end else if (ce) begin
      if (hold_connect) begin
        chan_r <= ctrl_r.chan;
      end
    end
  end

  // Hold switch opens at the end of the first bit period, stays open while busy
  assign hold_connect    = analog_power_en && (state_r == SEQ_IDLE || state_r == SEQ_RC_DELAY
                         || state_r == SEQ_SAMPLE);
  assign analog_power_en = ctrl_r.pwr_on && !pwr_down_r;
  assign mux_chan        = chan_r;

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= 8'h00;
      if (req.rd) begin
        unique case (req.addr)
          `ADC_OFS_CTRL:     rdata_r <= ctrl_r;
          `ADC_OFS_RESULT:   rdata_r <= conversion_result;
          `ADC_OFS_IRQ_STAT: rdata_r <= {7'h00, stat_done_r};
          `ADC_OFS_IRQ_MASK: rdata_r <= {7'h00, conversion_irq_enable};
          `ADC_OFS_STATE:    rdata_r <= {4'h0, state_r == SEQ_ABORT_WAIT,
                                         analog_power_en, hold_connect, busy};
          default:           rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata            = rdata_r;
  assign conversion_done_flag = stat_done_r;
  // Level interrupt while an enabled flag stands
  assign irq                  = stat_done_r && conversion_irq_enable;

endmodule // adc_sleep_reset_control

// ==== tb/adc_ctl_sva.sv ====
// Port checks for the converter control block
`timescale 1ns/1ps
module adc_ctl_sva (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Halt, analog side, interrupt
  input wire logic       halt_active,
  input wire logic       wake_req,
  input wire logic [2:0] mux_chan,
  input wire logic       hold_connect,
  input wire logic       analog_power_en,
  input wire logic       irq,
  input wire logic       conversion_done_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Clock select shadow, since the select field is not a port
  logic [1:0] sel_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      sel_r <= 2'h0;
    else if (reg_wr && reg_addr == 4'h0)
      sel_r <= reg_wdata[7:6];
  end
  // Start write with power on for a given clock select
  sequence s_go(logic [1:0] sel);
    reg_wr && reg_addr == 4'h0 && reg_wdata[7:6] == sel && reg_wdata[2] && reg_wdata[0];
  endsequence
  sequence s_halt_osc;
    $rose(halt_active) && sel_r != 2'h3;
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_irq_flag: assert property (irq |-> conversion_done_flag)
    else $error("interrupt without done flag");
  a_flag_sticky: assert property (
    conversion_done_flag && !(reg_wr && reg_addr == 4'h8 && reg_wdata[0])
    |=> conversion_done_flag) else $error("done flag dropped");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake longer than one cycle");
  a_wake_cause: assert property (wake_req |-> $past(halt_active))
    else $error("wake outside halt");
  a_mux_frozen: assert property (!hold_connect |=> $stable(mux_chan))
    else $error("channel moved with hold open");
  a_osc_sample: assert property (s_go(2'h0) |-> ##[1:4] !hold_connect)
    else $error("hold not opened after one bit period");
  a_rc_delay: assert property (s_go(2'h3) ##0 analog_power_en |=> hold_connect [*3])
    else $error("rc start not delayed");
  a_osc_halt_off: assert property (s_halt_osc |-> ##[1:2] !analog_power_en)
    else $error("oscillator halt kept power");
endmodule // adc_ctl_sva

bind adc_sleep_reset_control adc_ctl_sva adc_ctl_sva_inst (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_active(halt_active),
  .wake_req(wake_req), .mux_chan(mux_chan), .hold_connect(hold_connect),
  .analog_power_en(analog_power_en), .irq(irq), .conversion_done_flag(conversion_done_flag));

// ==== tb/proc_analog_model.sv ====
// Processor halt model with comparator and free running RC oscillator
`timescale 1ns/1ps
module proc_analog_model (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Firmware halt control
  input wire logic       sleep_cmd,
  input wire logic       resume_cmd,
  input wire logic       wake_req,
  output logic           halt_active,
  output int             wake_seen,
  // Analog side
  input wire logic [7:0] level,
  input wire logic [7:0] dac_code,
  output logic           cmp_hi_in,
  output logic           rc_osc_in
);
  // Halt is left on a wake pulse or an outside resume
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      halt_active <= 1'b0;
    else if (wake_req || resume_cmd)
      halt_active <= 1'b0;
    else if (sleep_cmd)
      halt_active <= 1'b1; // Halt entered after go
  end
  // Wake pulses counted for the bench
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      wake_seen <= 0;
    else if (wake_req)
      wake_seen <= wake_seen + 1;
  end
  // Ideal comparator, input level in LSB steps
  assign cmp_hi_in = (level >= dac_code);
  // RC period unrelated to the core clock
  initial rc_osc_in = 1'b0;
  always #97 rc_osc_in = ~rc_osc_in;
endmodule // proc_analog_model

// ==== tb/adc_sleep_reset_control_tb.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_sleep_reset_control_tb;
  import adc_ctl_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       sleep_cmd = 1'b0;
  logic       resume_cmd = 1'b0;
  logic [7:0] level = 8'h00;
  logic [7:0] reg_rdata, dac_code;
  logic [2:0] mux_chan;
  logic       halt_active, wake_req, rc_osc_in, cmp_hi_in;
  logic       hold_connect, analog_power_en, irq, conversion_done_flag;
  int         wake_seen, t0;
  int         err_total = 0;
  int         n_compared = 0;
  int         cyc = 0;
  logic [7:0] lv [3] = '{8'h01, 8'hFF, 8'hA5};
  int         dv [3] = '{2, 8, 32}; // Per-bit periods firmware picks

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  adc_sleep_reset_control adc_sleep_reset_control_inst (
    .core_clk(core_clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_active(halt_active), .wake_req(wake_req), .rc_osc_in(rc_osc_in),
    .cmp_hi_in(cmp_hi_in), .dac_code(dac_code), .mux_chan(mux_chan),
    .hold_connect(hold_connect), .analog_power_en(analog_power_en), .irq(irq),
    .conversion_done_flag(conversion_done_flag));

  proc_analog_model proc_analog_model_inst (
    .core_clk(core_clk), .rst(rst), .sleep_cmd(sleep_cmd), .resume_cmd(resume_cmd),
    .wake_req(wake_req), .halt_active(halt_active), .wake_seen(wake_seen),
    .level(level), .dac_code(dac_code), .cmp_hi_in(cmp_hi_in), .rc_osc_in(rc_osc_in));

  task automatic complete_run();
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata & m, e);
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (conversion_done_flag !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 3000) chk(8'h00, 8'h01);
  endtask

  task automatic halt_pulse(input logic s);
    @(posedge core_clk);
    if (s) sleep_cmd <= 1'b1; else resume_cmd <= 1'b1;
    @(posedge core_clk);
    sleep_cmd <= 1'b0;
    resume_cmd <= 1'b0;
  endtask

  // Hang guard well above the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // Reset state, unmapped offset reads zero
    rd(4'h0, 8'h00); // Control cleared
    rd(4'h1, 8'h00); // Idle and unpowered
    rd(4'hC, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'hC, 8'h01);
    // Every oscillator select, timing and result
    for (int s = 0; s < 3; s++) begin
      level <= lv[s];
      wr(4'h0, {s[1:0], 6'h01});
      wr(4'h0, {s[1:0], 6'h05});
      t0 = cyc;
      if (s == 2) begin
        repeat (40) @(posedge core_clk);
        wr(4'h0, 8'hAD);
        repeat (2) @(negedge core_clk);
        chk({5'h0, mux_chan}, 8'h00); // Late channel change ignored
      end
      wait_flag();
      chk({7'h0, (cyc - t0 >= 9 * dv[s]) && (cyc - t0 <= 9 * dv[s] + 4)}, 8'h01); // Bit period
      chk({7'h0, irq}, 8'h01); // Unmasked flag raises irq
      rd(4'h8, 8'h01); // Done flag set
      rd(4'h0, (s == 2) ? 8'hA9 : {s[1:0], 6'h01}); // Go cleared
      rd(4'h4, lv[s]); // Result loaded, first step at one LSB
      wr(4'h8, 8'h01);
      @(negedge core_clk);
      chk({7'h0, irq}, 8'h00); // Cleared flag
    end
    // Abort keeps the written result, then a two period wait
    wr(4'h4, 8'h3C);
    wr(4'h0, 8'h85);
    repeat (100) @(posedge core_clk);
    wr(4'h0, 8'h81);
    rd(4'h1, 8'h08, 8'h0A); // Waiting with hold open
    repeat (80) @(posedge core_clk);
    rd(4'h1, 8'h02, 8'h0A); // Acquisition resumed
    rd(4'h4, 8'h3C); // Partial result dropped
    chk({7'h0, conversion_done_flag}, 8'h00); // No flag on abort
    // RC conversion in halt, interrupt enabled then disabled
    for (int m = 1; m >= 0; m--) begin
      wr(4'hC, m[7:0]);
      wr(4'h0, 8'hC1);
      level <= 8'h5A;
      wr(4'h0, 8'hC5);
      halt_pulse(1'b1); // Go first, then halt
      wait_flag();
      repeat (2) @(negedge core_clk);
      chk(wake_seen[7:0], 8'h01); // Wake only when enabled
      chk({7'h0, analog_power_en}, m[7:0]); // Powered down if disabled
      chk({7'h0, irq}, m[7:0]); // Masked flag keeps irq low
      rd(4'h0, 8'hC1); // Power bit kept, go cleared
      rd(4'h4, 8'h5A); // Conversion survived halt
      halt_pulse(1'b0);
      wr(4'h8, 8'h01);
    end
    // Oscillator clock: halt aborts and powers down
    wr(4'h0, 8'h41);
    wr(4'h0, 8'h45);
    repeat (5) @(posedge core_clk);
    halt_pulse(1'b1);
    repeat (3) @(negedge core_clk);
    chk({7'h0, analog_power_en}, 8'h00); // Halt powers down
    rd(4'h0, 8'h41); // Power bit stays
    halt_pulse(1'b0);
    repeat (120) @(posedge core_clk);
    chk({7'h0, conversion_done_flag}, 8'h00); // Aborted, never completes
    // Reset in mid conversion
    wr(4'h0, 8'h85);
    repeat (50) @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0, 8'h00); // Control back to reset value
    rd(4'h1, 8'h00); // Conversion aborted
    chk({7'h0, analog_power_en}, 8'h00); // Powered down
    chk(dac_code, 8'h00); // Trial code cleared
    complete_run();
  end
endmodule // adc_sleep_reset_control_tb
